// *** rtl/pot_pkg.sv ***
// shared constants and helpers for the overhead tdm port
package pot_pkg;
   // ==========================================================
   // slot frame
   localparam int NUM_CH = 12;
   localparam int SLOT_W = 4;
   localparam logic [SLOT_W-1:0] SLOT_FIRST = 4'h0;
   // rising link edges from a slot's strobes to its transmit sampling
   localparam int TX_LAT = 3;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int OVH_MIN_MHZ = 10;
   localparam int OVH_MAX_MHZ = 52;
   localparam int OVH_PERIOD_NS = 80;
   localparam int OVH_HALF_CYC = (OVH_PERIOD_NS * 1000) / (2 * CLK_PERIOD_PS);
   localparam int DIV_W = 8;
   // ==========================================================
   // helpers
   function automatic logic [SLOT_W-1:0] slot_inc(input logic [SLOT_W-1:0] s,
                                                  input logic [SLOT_W-1:0] last);
      if (s >= last) begin
         slot_inc = SLOT_FIRST;
      end else begin
         slot_inc = s + 4'h1;
      end
   endfunction
endpackage

// *** rtl/pot_if.sv ***
// link wires between the framer end and the external overhead logic
`timescale 1ns/1ps
interface pot_if;
   logic ovh_port_clock;
   logic slot_one_marker;
   logic tx_slot_valid;
   logic tx_ovh_frame_start;
   logic rx_slot_valid;
   logic rx_ovh_frame_start;
   logic rx_ovh_bit_out;
   logic tx_ovh_bit_in;
   logic tx_ovh_bit_enable;

   modport dev (
      input ovh_port_clock, tx_ovh_bit_in, tx_ovh_bit_enable,
      output slot_one_marker, tx_slot_valid, tx_ovh_frame_start,
      output rx_slot_valid, rx_ovh_frame_start, rx_ovh_bit_out
   );
   modport ext (
      output ovh_port_clock, tx_ovh_bit_in, tx_ovh_bit_enable,
      input slot_one_marker, tx_slot_valid, tx_ovh_frame_start,
      input rx_slot_valid, rx_ovh_frame_start, rx_ovh_bit_out
   );
endinterface

// *** rtl/pot_sync.sv ***
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module pot_sync #(
   parameter int W = 1
) (
   input logic CLK,        // system clock
   input logic RST,        // synchronous reset, high
   input logic [W-1:0] D,  // asynchronous levels
   output logic [W-1:0] Q  // synchronised levels
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   always_comb begin
      meta_nxt = D;
      q_nxt = meta_r;
      if (RST) begin
         meta_nxt = '0;
         q_nxt = '0;
      end
   end

   always_ff @(posedge CLK) begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
   end

   assign Q = q_r;
endmodule

// *** rtl/pot_dev.sv ***
// framer end of the multiplexed plcp overhead port
`timescale 1ns/1ps
module pot_dev #(
   parameter int N = pot_pkg::NUM_CH
) (
   input logic CLK,                                  // system clock
   input logic RST,                                  // synchronous reset, high
   input logic [N-1:0] PLCP_MODE,                    // channel framer in plcp mode
   input logic [N-1:0] OVH_PORT_EN,                  // channel overhead port enabled
   input logic [N-1:0] RX_BIT,                       // received overhead bit per channel
   input logic [N-1:0] RX_SOF,                       // bit is first of rx overhead sequence
   input logic [N-1:0] TX_SOF,                       // next bit precedes tx frame start
   output logic SLOT_STB,                            // pulse: a slot went out on the link
   output logic [pot_pkg::SLOT_W-1:0] SLOT_CH,       // channel of that slot
   output logic REPL_STB,                            // pulse: replace one tx overhead bit
   output logic [pot_pkg::SLOT_W-1:0] REPL_CH,       // channel of the replacement
   output logic REPL_BIT,                            // replacement value
   output logic REPL_FIRST,                          // replacement is first bit of frame
   pot_if.dev lnk                                    // link to external logic
);
   // ==========================================================
   // checks
   if (N < 2 || N > (1 << pot_pkg::SLOT_W)) begin : g_chk
      $error("pot_dev: channel count does not fit the slot counter");
   end

   localparam logic [pot_pkg::SLOT_W-1:0] SLOT_LAST = pot_pkg::SLOT_W'(N - 1);
   localparam int PL = pot_pkg::TX_LAT;

   // ==========================================================
   // pin synchronisers and edge finding
   logic [2:0] pins_s;
   logic s_clk;
   logic s_bit;
   logic s_en;
   logic rise;

   pot_sync #(.W(3)) u_sync (
      .CLK(CLK),
      .RST(RST),
      .D({lnk.ovh_port_clock, lnk.tx_ovh_bit_in, lnk.tx_ovh_bit_enable}),
      .Q(pins_s)
   );

   assign s_clk = pins_s[2];
   assign s_bit = pins_s[1];
   assign s_en = pins_s[0];

   logic clk_d_r;
   logic clk_d_nxt;

   // the synced copy and its delayed copy give the rising edge
   assign rise = s_clk & ~clk_d_r;

   // ==========================================================
   // state
   logic [pot_pkg::SLOT_W-1:0] slot_r;
   logic [pot_pkg::SLOT_W-1:0] slot_nxt;
   logic marker_r;
   logic marker_nxt;
   logic txv_r;
   logic txv_nxt;
   logic txs_r;
   logic txs_nxt;
   logic rxv_r;
   logic rxv_nxt;
   logic rxs_r;
   logic rxs_nxt;
   logic rxb_r;
   logic rxb_nxt;
   logic pv_r [PL];
   logic pv_nxt [PL];
   logic [pot_pkg::SLOT_W-1:0] pch_r [PL];
   logic [pot_pkg::SLOT_W-1:0] pch_nxt [PL];
   logic psof_r [PL];
   logic psof_nxt [PL];
   logic slot_stb_r;
   logic slot_stb_nxt;
   logic [pot_pkg::SLOT_W-1:0] slot_ch_r;
   logic [pot_pkg::SLOT_W-1:0] slot_ch_nxt;
   logic repl_stb_r;
   logic repl_stb_nxt;
   logic [pot_pkg::SLOT_W-1:0] repl_ch_r;
   logic [pot_pkg::SLOT_W-1:0] repl_ch_nxt;
   logic repl_bit_r;
   logic repl_bit_nxt;
   logic repl_first_r;
   logic repl_first_nxt;

   logic [N-1:0] active;
   logic cur_act;

   assign active = PLCP_MODE & OVH_PORT_EN;
   assign cur_act = active[slot_r];

   // ==========================================================
   // next values
   always_comb begin
      clk_d_nxt = s_clk;
      slot_nxt = slot_r;
      marker_nxt = marker_r;
      txv_nxt = txv_r;
      txs_nxt = txs_r;
      rxv_nxt = rxv_r;
      rxs_nxt = rxs_r;
      rxb_nxt = rxb_r;
      for (int i = 0; i < PL; i++) begin
         pv_nxt[i] = pv_r[i];
         pch_nxt[i] = pch_r[i];
         psof_nxt[i] = psof_r[i];
      end
      slot_stb_nxt = 1'b0;
      slot_ch_nxt = slot_ch_r;
      repl_stb_nxt = 1'b0;
      repl_ch_nxt = repl_ch_r;
      repl_bit_nxt = repl_bit_r;
      repl_first_nxt = repl_first_r;
      if (rise) begin
         // slot counter runs even with no channel active, so the
         // first marker after enabling lands on a whole frame
         slot_nxt = pot_pkg::slot_inc(slot_r, SLOT_LAST);
         marker_nxt = (|PLCP_MODE) && (slot_r == pot_pkg::SLOT_FIRST);
         txv_nxt = cur_act;
         txs_nxt = cur_act & TX_SOF[slot_r];
         rxv_nxt = cur_act;
         rxs_nxt = cur_act & RX_SOF[slot_r];
         rxb_nxt = cur_act & RX_BIT[slot_r];
         slot_stb_nxt = 1'b1;
         slot_ch_nxt = slot_r;
         // oldest stage was sent three rising edges ago
         if (pv_r[PL-1] && s_en) begin
            repl_stb_nxt = 1'b1;
            repl_ch_nxt = pch_r[PL-1];
            repl_bit_nxt = s_bit;
            repl_first_nxt = psof_r[PL-1];
         end
         for (int i = PL - 1; i > 0; i--) begin
            pv_nxt[i] = pv_r[i-1];
            pch_nxt[i] = pch_r[i-1];
            psof_nxt[i] = psof_r[i-1];
         end
         pv_nxt[0] = cur_act;
         pch_nxt[0] = slot_r;
         psof_nxt[0] = cur_act & TX_SOF[slot_r];
      end
      if (RST) begin
         clk_d_nxt = 1'b0;
         slot_nxt = pot_pkg::SLOT_FIRST;
         marker_nxt = 1'b0;
         txv_nxt = 1'b0;
         txs_nxt = 1'b0;
         rxv_nxt = 1'b0;
         rxs_nxt = 1'b0;
         rxb_nxt = 1'b0;
         for (int i = 0; i < PL; i++) begin
            pv_nxt[i] = 1'b0;
            pch_nxt[i] = pot_pkg::SLOT_FIRST;
            psof_nxt[i] = 1'b0;
         end
         slot_stb_nxt = 1'b0;
         slot_ch_nxt = pot_pkg::SLOT_FIRST;
         repl_stb_nxt = 1'b0;
         repl_ch_nxt = pot_pkg::SLOT_FIRST;
         repl_bit_nxt = 1'b0;
         repl_first_nxt = 1'b0;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge CLK) begin
      clk_d_r <= clk_d_nxt;
      slot_r <= slot_nxt;
      marker_r <= marker_nxt;
      txv_r <= txv_nxt;
      txs_r <= txs_nxt;
      rxv_r <= rxv_nxt;
      rxs_r <= rxs_nxt;
      rxb_r <= rxb_nxt;
      for (int i = 0; i < PL; i++) begin
         pv_r[i] <= pv_nxt[i];
         pch_r[i] <= pch_nxt[i];
         psof_r[i] <= psof_nxt[i];
      end
      slot_stb_r <= slot_stb_nxt;
      slot_ch_r <= slot_ch_nxt;
      repl_stb_r <= repl_stb_nxt;
      repl_ch_r <= repl_ch_nxt;
      repl_bit_r <= repl_bit_nxt;
      repl_first_r <= repl_first_nxt;
   end

   // ==========================================================
   // outputs
   assign lnk.slot_one_marker = marker_r;
   assign lnk.tx_slot_valid = txv_r;
   assign lnk.tx_ovh_frame_start = txs_r;
   assign lnk.rx_slot_valid = rxv_r;
   assign lnk.rx_ovh_frame_start = rxs_r;
   assign lnk.rx_ovh_bit_out = rxb_r;
   assign SLOT_STB = slot_stb_r;
   assign SLOT_CH = slot_ch_r;
   assign REPL_STB = repl_stb_r;
   assign REPL_CH = repl_ch_r;
   assign REPL_BIT = repl_bit_r;
   assign REPL_FIRST = repl_first_r;
endmodule

// *** rtl/pot_ext.sv ***
// external end: makes the link clock, demultiplexes rx, multiplexes tx
`timescale 1ns/1ps
module pot_ext #(
   parameter int N = pot_pkg::NUM_CH,
   parameter int HALF = pot_pkg::OVH_HALF_CYC
) (
   input logic CLK,                                  // system clock
   input logic RST,                                  // synchronous reset, high
   input logic [N-1:0] TX_BIT,                       // overhead bit to insert per channel
   input logic [N-1:0] TX_EN,                        // insert this bit per channel
   output logic RX_STB,                              // pulse: one rx slot captured
   output logic [pot_pkg::SLOT_W-1:0] RX_CH,         // channel of that slot
   output logic RX_BIT,                              // captured overhead bit
   output logic RX_SOF,                              // bit starts overhead sequence
   output logic TXS_STB,                             // pulse: tx slot valid seen
   output logic [pot_pkg::SLOT_W-1:0] TXS_CH,        // channel of that tx slot
   output logic TXS_SOF,                             // next tx bit precedes frame start
   output logic SYNC_OK,                             // marker seen, slots attributed
   pot_if.ext lnk                                    // link to the framer end
);
   localparam int FREQ_KHZ = 1000000000 / (2 * HALF * pot_pkg::CLK_PERIOD_PS);
   if (N < 2 || N > (1 << pot_pkg::SLOT_W) || HALF < 8 || HALF > 255 ||
       FREQ_KHZ < pot_pkg::OVH_MIN_MHZ * 1000 || FREQ_KHZ > pot_pkg::OVH_MAX_MHZ * 1000)
   begin : g_chk
      $error("pot_ext: link clock or channel count out of range");
   end

   localparam logic [pot_pkg::SLOT_W-1:0] SLOT_LAST = pot_pkg::SLOT_W'(N - 1);
   localparam logic [pot_pkg::DIV_W-1:0] DIV_LAST = pot_pkg::DIV_W'(HALF - 1);
   // falling edges from a capture to the drive that the framer samples
   localparam int PL = pot_pkg::TX_LAT - 1;

   // ==========================================================
   // synchronised link inputs
   logic [5:0] pins_s;
   pot_sync #(.W(6)) u_sync (
      .CLK(CLK),
      .RST(RST),
      .D({lnk.slot_one_marker, lnk.tx_slot_valid, lnk.tx_ovh_frame_start,
          lnk.rx_slot_valid, lnk.rx_ovh_frame_start, lnk.rx_ovh_bit_out}),
      .Q(pins_s)
   );

   // ==========================================================
   // state
   logic [pot_pkg::DIV_W-1:0] div_r, div_nxt;
   logic ck_r, ck_nxt;
   logic fall;
   logic [pot_pkg::SLOT_W-1:0] slot_r, slot_nxt, cur;
   logic sync_r, sync_nxt;
   logic pv_r [PL];
   logic pv_nxt [PL];
   logic [pot_pkg::SLOT_W-1:0] pch_r [PL];
   logic [pot_pkg::SLOT_W-1:0] pch_nxt [PL];
   logic tb_r, tb_nxt, te_r, te_nxt;
   logic rxstb_r, rxstb_nxt, rxb_r, rxb_nxt, rxs_r, rxs_nxt;
   logic [pot_pkg::SLOT_W-1:0] rxch_r, rxch_nxt, txch_r, txch_nxt;
   logic txstb_r, txstb_nxt, txs_r, txs_nxt;

   // outputs settle about five cycles after a rising edge; half period is longer
   assign fall = ck_r && (div_r == DIV_LAST);
   assign cur = pins_s[5] ? pot_pkg::SLOT_FIRST : slot_r;

   always_comb begin
      div_nxt = (div_r == DIV_LAST) ? '0 : div_r + 8'h01;
      ck_nxt = (div_r == DIV_LAST) ? ~ck_r : ck_r;
      slot_nxt = slot_r;
      sync_nxt = sync_r;
      for (int i = 0; i < PL; i++) begin
         pv_nxt[i] = pv_r[i];
         pch_nxt[i] = pch_r[i];
      end
      tb_nxt = tb_r;
      te_nxt = te_r;
      rxstb_nxt = 1'b0;
      rxch_nxt = rxch_r;
      rxb_nxt = rxb_r;
      rxs_nxt = rxs_r;
      txstb_nxt = 1'b0;
      txch_nxt = txch_r;
      txs_nxt = txs_r;
      if (fall) begin
         slot_nxt = pot_pkg::slot_inc(cur, SLOT_LAST);
         sync_nxt = sync_r | pins_s[5];
         if ((sync_r | pins_s[5]) && pins_s[2]) begin
            rxstb_nxt = 1'b1;
            rxch_nxt = cur;
            rxs_nxt = pins_s[1];
            rxb_nxt = pins_s[0];
         end
         if ((sync_r | pins_s[5]) && pins_s[4]) begin
            txstb_nxt = 1'b1;
            txch_nxt = cur;
            txs_nxt = pins_s[3];
         end
         // drive now what the framer samples at its next rising edge
         tb_nxt = pv_r[PL-1] & TX_BIT[pch_r[PL-1]];
         te_nxt = pv_r[PL-1] & TX_EN[pch_r[PL-1]];
         for (int i = PL - 1; i > 0; i--) begin
            pv_nxt[i] = pv_r[i-1];
            pch_nxt[i] = pch_r[i-1];
         end
         pv_nxt[0] = (sync_r | pins_s[5]) & pins_s[4];
         pch_nxt[0] = cur;
      end
      if (RST) begin
         div_nxt = '0;
         ck_nxt = 1'b0;
         slot_nxt = pot_pkg::SLOT_FIRST;
         sync_nxt = 1'b0;
         for (int i = 0; i < PL; i++) begin
            pv_nxt[i] = 1'b0;
            pch_nxt[i] = pot_pkg::SLOT_FIRST;
         end
         tb_nxt = 1'b0;
         te_nxt = 1'b0;
         rxstb_nxt = 1'b0;
         rxch_nxt = pot_pkg::SLOT_FIRST;
         rxb_nxt = 1'b0;
         rxs_nxt = 1'b0;
         txstb_nxt = 1'b0;
         txch_nxt = pot_pkg::SLOT_FIRST;
         txs_nxt = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      div_r <= div_nxt;
      ck_r <= ck_nxt;
      slot_r <= slot_nxt;
      sync_r <= sync_nxt;
      for (int i = 0; i < PL; i++) begin
         pv_r[i] <= pv_nxt[i];
         pch_r[i] <= pch_nxt[i];
      end
      tb_r <= tb_nxt;
      te_r <= te_nxt;
      rxstb_r <= rxstb_nxt;
      rxch_r <= rxch_nxt;
      rxb_r <= rxb_nxt;
      rxs_r <= rxs_nxt;
      txstb_r <= txstb_nxt;
      txch_r <= txch_nxt;
      txs_r <= txs_nxt;
   end

   assign lnk.ovh_port_clock = ck_r;
   assign lnk.tx_ovh_bit_in = tb_r;
   assign lnk.tx_ovh_bit_enable = te_r;
   assign RX_STB = rxstb_r;
   assign RX_CH = rxch_r;
   assign RX_BIT = rxb_r;
   assign RX_SOF = rxs_r;
   assign TXS_STB = txstb_r;
   assign TXS_CH = txch_r;
   assign TXS_SOF = txs_r;
   assign SYNC_OK = sync_r;
endmodule

// *** test/pot_props.sv ***
// assertions on the overhead tdm link wires
`timescale 1ns/1ps
module pot_props #(
   parameter int HALF = 8
) (
   input logic CLK,                // system clock
   input logic RST,                // synchronous reset, high
   input logic ovh_port_clock,     // link clock
   input logic slot_one_marker,    // channel one marker
   input logic tx_slot_valid,      // tx slot valid
   input logic tx_ovh_frame_start, // tx frame start
   input logic rx_slot_valid,      // rx slot valid
   input logic rx_ovh_frame_start, // rx frame start
   input logic rx_ovh_bit_out,     // rx overhead bit
   input logic tx_ovh_bit_in,      // tx overhead bit
   input logic tx_ovh_bit_enable   // tx bit enable
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   logic [5:0] dev_o;
   int hi_r;
   int hi_nxt;
   int gap_r;
   int gap_nxt;
   logic mk_d_r;
   logic mk_d_nxt;
   logic seen_r;
   logic seen_nxt;
   assign dev_o = {slot_one_marker, tx_slot_valid, tx_ovh_frame_start,
      rx_slot_valid, rx_ovh_frame_start, rx_ovh_bit_out};
   // ==========================================================
   // marker width and spacing counters
   always_comb begin
      hi_nxt = slot_one_marker ? hi_r + 1 : 0;
      gap_nxt = (slot_one_marker && !mk_d_r) ? 1 : gap_r + 1;
      seen_nxt = seen_r | (slot_one_marker & !mk_d_r);
      mk_d_nxt = slot_one_marker;
      if (RST) begin
         hi_nxt = 0;
         gap_nxt = 0;
         seen_nxt = 1'b0;
         mk_d_nxt = 1'b0;
      end
   end
   always_ff @(posedge CLK) begin
      hi_r <= hi_nxt;
      gap_r <= gap_nxt;
      mk_d_r <= mk_d_nxt;
      seen_r <= seen_nxt;
   end
   // ==========================================================
   // properties
   reset_low_a: assert property (disable iff (1'b0) RST |=> dev_o == 6'h00)
      else $error("link output not low in reset");
   out_edge_a: assert property (
      $changed(dev_o) |-> ovh_port_clock && $past(ovh_port_clock, 2))
      else $error("link output moved away from rising link edge");
   tx_pin_edge_a: assert property (
      $changed({tx_ovh_bit_in, tx_ovh_bit_enable}) |-> $fell(ovh_port_clock))
      else $error("tx pins moved away from falling link edge");
   clk_high_a: assert property (
      $rose(ovh_port_clock) |-> ovh_port_clock[*8] ##1 !ovh_port_clock)
      else $error("link clock high phase wrong");
   // a stretched low phase would be a gap in the link clock
   clk_low_a: assert property (
      $fell(ovh_port_clock) |-> (!ovh_port_clock)[*8] ##1 ovh_port_clock)
      else $error("link clock low phase wrong");
   marker_width_a: assert property ($fell(slot_one_marker) |-> hi_r == 2 * HALF)
      else $error("marker not one link period wide");
   marker_period_a: assert property (
      slot_one_marker && !mk_d_r && seen_r |-> gap_r == 24 * HALF)
      else $error("marker not every twelve slots");
   valid_pair_a: assert property (tx_slot_valid == rx_slot_valid)
      else $error("tx and rx valid differ");
   rx_qual_a: assert property (rx_ovh_frame_start || rx_ovh_bit_out |-> rx_slot_valid)
      else $error("rx start or data outside valid slot");
   tx_qual_a: assert property (tx_ovh_frame_start |-> tx_slot_valid)
      else $error("tx start outside valid slot");
   cover property (slot_one_marker && rx_ovh_frame_start);
   cover property (slot_one_marker && tx_ovh_frame_start);
   cover property ($rose(tx_ovh_bit_enable));
endmodule

// *** test/test_plcp_overhead_tdm_port.sv ***
// self-checking bench: framer end and external end joined on the link
`timescale 1ns/1ps
module test_plcp_overhead_tdm_port;
   logic CLK;
   logic RST;
   logic [11:0] mode, en, rxb, rxs, txs, txb, txe, act;
   logic slot_stb, repl_stb, repl_bit, repl_first, rx_stb, rx_bit, rx_sof;
   logic txs_stb, txs_sof, sync_ok;
   logic [3:0] slot_ch, repl_ch, rx_ch, txs_ch;
   logic [7:0] lnk_all;
   int error_cnt;
   int checks;
   logic [5:0] smp[$];
   logic [5:0] rxq[$];
   logic [5:0] rpq[$];
   logic [4:0] txq[$];
   logic [3:0] slq[$];
   pot_if lnk_if ();
   pot_dev pot_dev_inst (.CLK(CLK), .RST(RST), .PLCP_MODE(mode), .OVH_PORT_EN(en),
      .RX_BIT(rxb), .RX_SOF(rxs), .TX_SOF(txs), .SLOT_STB(slot_stb), .SLOT_CH(slot_ch),
      .REPL_STB(repl_stb), .REPL_CH(repl_ch), .REPL_BIT(repl_bit),
      .REPL_FIRST(repl_first), .lnk(lnk_if.dev));
   pot_ext pot_ext_inst (.CLK(CLK), .RST(RST), .TX_BIT(txb), .TX_EN(txe), .RX_STB(rx_stb),
      .RX_CH(rx_ch), .RX_BIT(rx_bit), .RX_SOF(rx_sof), .TXS_STB(txs_stb), .TXS_CH(txs_ch),
      .TXS_SOF(txs_sof), .SYNC_OK(sync_ok), .lnk(lnk_if.ext));
   pot_props #(.HALF(pot_pkg::OVH_HALF_CYC)) pot_props_inst (.CLK(CLK), .RST(RST),
      .ovh_port_clock(lnk_if.ovh_port_clock), .slot_one_marker(lnk_if.slot_one_marker),
      .tx_slot_valid(lnk_if.tx_slot_valid), .tx_ovh_frame_start(lnk_if.tx_ovh_frame_start),
      .rx_slot_valid(lnk_if.rx_slot_valid), .rx_ovh_frame_start(lnk_if.rx_ovh_frame_start),
      .rx_ovh_bit_out(lnk_if.rx_ovh_bit_out), .tx_ovh_bit_in(lnk_if.tx_ovh_bit_in),
      .tx_ovh_bit_enable(lnk_if.tx_ovh_bit_enable));
   assign lnk_all = {lnk_if.slot_one_marker, lnk_if.tx_slot_valid, lnk_if.tx_ovh_frame_start,
      lnk_if.rx_slot_valid, lnk_if.rx_ovh_frame_start, lnk_if.rx_ovh_bit_out,
      lnk_if.tx_ovh_bit_in, lnk_if.tx_ovh_bit_enable};
   // ==========================================================
   // clock and monitors
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   // outside logic takes the link outputs on the falling link edge
   always @(negedge lnk_if.ovh_port_clock) smp.push_back(lnk_all[7:2]);
   always @(posedge CLK) begin
      if (rx_stb) rxq.push_back({rx_ch, rx_bit, rx_sof});
      if (repl_stb) rpq.push_back({repl_ch, repl_bit, repl_first});
      if (txs_stb) txq.push_back({txs_ch, txs_sof});
      if (slot_stb) slq.push_back(slot_ch);
   end
   // ==========================================================
   // shared tasks
   task automatic summarize;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic run(input int n);
      smp.delete();
      rxq.delete();
      rpq.delete();
      txq.delete();
      slq.delete();
      for (int i = 0; i < 40 * n && smp.size() < n; i++) @(posedge CLK);
   endtask
   task automatic wait_sync;
      for (int i = 0; i < 1000 && sync_ok !== 1'b1; i++) @(posedge CLK);
      chk(sync_ok === 1'b1, "no slot sync");
   endtask
   task automatic setup(input logic [11:0] m, e, b, s, t, x, y);
      @(posedge CLK);
      mode <= m;
      en <= e;
      rxb <= b;
      rxs <= s;
      txs <= t;
      txb <= x;
      txe <= y;
      act = m & e;
      // flush slots still carrying the old setup through the tx pipeline
      run(5);
   endtask
   task automatic judge(input logic any);
      int m0;
      int c;
      logic a;
      logic [11:0] seen;
      logic [5:0] e;
      m0 = -1;
      seen = 12'h000;
      run(30);
      foreach (smp[i]) if (m0 < 0 && smp[i][5]) m0 = i;
      chk((m0 >= 0 && m0 < 12) == any, "marker presence");
      foreach (smp[i]) begin
         c = (i - m0 + 12) % 12;
         a = act[c];
         e = {any && c == 0, a, a & txs[c], a, a & rxs[c], a & rxb[c]};
         chk(smp[i] === e, "link slot");
      end
      foreach (rxq[i]) begin
         c = rxq[i][5:2];
         chk(act[c] === 1'b1 && rxq[i][1:0] === {rxb[c], rxs[c]}, "rx report");
      end
      chk(!any || rxq.size() >= 12, "rx report count");
      foreach (txq[i]) begin
         c = txq[i][4:1];
         chk(act[c] === 1'b1 && txq[i][0] === txs[c], "tx slot report");
      end
      chk(!any || txq.size() >= 12, "tx report count");
      // slots leave in fixed rotation whatever the channel setup
      foreach (slq[i]) begin
         chk(slq[i] === 4'((slq[0] + i) % pot_pkg::NUM_CH), "slot order");
      end
      chk(slq.size() >= 29, "slot count");
      foreach (rpq[i]) begin
         c = rpq[i][5:2];
         seen[c] = 1'b1;
         chk(rpq[i][1:0] === {txb[c], txs[c]}, "replaced bit");
      end
      chk(seen === (act & txe), "replaced channels");
   endtask
   // ==========================================================
   // scenarios
   task automatic scen_mixed;
      setup(12'hfdf, 12'hf77, 12'ha5c, 12'h005, 12'h010, 12'h96c, 12'hf0f);
      judge(1'b1);
   endtask
   task automatic scen_reset;
      @(posedge CLK);
      RST <= 1'b1;
      repeat (5) @(posedge CLK);
      #1;
      chk(lnk_all === 8'h00 && slot_stb === 1'b0 && repl_stb === 1'b0 &&
         rx_stb === 1'b0 && txs_stb === 1'b0 && sync_ok === 1'b0, "reset outputs");
      @(posedge CLK);
      RST <= 1'b0;
      wait_sync();
      judge(1'b1);
   endtask
   task automatic scen_full;
      setup(12'hfff, 12'hfff, 12'h5a3, 12'h800, 12'h001, 12'h693, 12'h0f1);
      judge(1'b1);
   endtask
   task automatic scen_off;
      setup(12'h000, 12'hfff, 12'hfff, 12'hfff, 12'hfff, 12'hfff, 12'hfff);
      judge(1'b0);
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      error_cnt = 0;
      checks = 0;
      RST = 1'b1;
      mode = 12'hfdf;
      en = 12'hf77;
      rxb = 12'h000;
      rxs = 12'h000;
      txs = 12'h000;
      txb = 12'h000;
      txe = 12'h000;
      act = 12'h000;
      repeat (5) @(posedge CLK);
      RST <= 1'b0;
      wait_sync();
      scen_mixed();
      scen_reset();
      scen_full();
      scen_off();
      summarize();
   end
   initial begin
      #60000;
      error_cnt++;
      summarize();
   end
endmodule
